// ==== logic/irq_controller.sv ====
// Summary of operation
// RULE_01 - Nine sources: five external pins, three timer overflows, one serial event.
// RULE_02 - Every source has flag, mask and vector; one global enable gates all.
// RULE_03 - Timer C shares a vector with external 3, timer D with external 4.
// RULE_04 - Control bits live at nibbles 00 to 03 and 22 to 23.
// RULE_05 - Software can only clear a request flag, never set it.
// RULE_06 - Reset clears enable and flags and sets every mask.
// RULE_07 - Flag set with mask clear is pending; serviced only with enable set.
// RULE_08 - Fixed priority decode yields the vector of the serviced source.
// RULE_09 - Ack: cycle one finishes instruction, two clears enable, three jumps.
// RULE_10 - Carry, status and program counter are pushed in cycles two and three.
// RULE_11 - Vectors 0002 to 000E by priority one to seven; reset at 0000.
// RULE_12 - Handler software jumps from the vector and clears the flag itself.
// RULE_13 - Return from interrupt sets the enable; acknowledge clears it.
// RULE_14 - Externals 0 and 1 fire on falling edge; 2 to 4 by edge select.
// RULE_15 - Acknowledge lowers the stack pointer by four; return raises it by four.
// RULE_16 - Timer flags set on overflow, timer D on capture edge, serial on done.
// RULE_17 - Among pending requests the lowest priority number wins.
// RULE_18 - Requests are sampled only at instruction boundaries.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module irq_controller (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic [4:0] ext_irq_in,
  input wire logic capture_event_in,
  input wire logic capture_mode_in,
  input wire logic timer_a_ovf_in,
  input wire logic timer_c_ovf_in,
  input wire logic timer_d_ovf_in,
  input wire logic serial_done_in,
  input wire logic instr_boundary_in,
  input wire logic irq_return_in,
  input wire logic [5:0] addr_in,
  input wire logic [3:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [3:0] rdata_out,
  output logic [1:0] ack_phase_out,
  output logic push_out,
  output logic jump_out,
  output logic [15:0] vector_out,
  output logic [9:0] stack_ptr_out,
  output logic global_irq_enable_out,
  output logic irq_pending_out
);
  irq_ctrl_pkg::ctl_state_t cur;
  irq_ctrl_pkg::ctl_state_t next_cur;
  irq_ctrl_pkg::nib_bus_t bus;
  logic [irq_ctrl_pkg::EDGE_N-1:0] pin_edge;
  logic [2*irq_ctrl_pkg::EDGE_N-1:0] edge_sel;
  logic [8:0] event_set;
  logic [8:0] req;
  logic [6:0] lvl_req;
  logic any_req;
  logic [15:0] pick_vector;

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  function automatic logic [23:0] pack_image(input logic ie, input logic [8:0] flag,
                                             input logic [8:0] mask);
    logic [23:0] img;
    img = 24'h000000;
    img[irq_ctrl_pkg::IE_POS] = ie;
    for (int i = 0; i < irq_ctrl_pkg::N_SRC; i++) begin
      img[irq_ctrl_pkg::F_POS[i]] = flag[i];
      img[irq_ctrl_pkg::F_POS[i] + 1] = mask[i];
    end
    return img;
  endfunction

  // Slot of a control nibble in the image, or 7 when the address is not one.
  function automatic logic [2:0] ctl_slot(input logic [5:0] addr);
    unique case (addr)
      irq_ctrl_pkg::A_CTL0: return 3'h0;
      irq_ctrl_pkg::A_CTL1: return 3'h1;
      irq_ctrl_pkg::A_CTL2: return 3'h2;
      irq_ctrl_pkg::A_CTL3: return 3'h3;
      irq_ctrl_pkg::A_CTL22: return 3'h4;
      irq_ctrl_pkg::A_CTL23: return 3'h5;
      default: return 3'h7;
    endcase
  endfunction

  // Capture edge, external 4..2 by selects, externals 1 and 0 fixed falling.
  assign edge_sel = {cur.esel_b, cur.esel_a, irq_ctrl_pkg::EDGE_FALL, irq_ctrl_pkg::EDGE_FALL}; // RULE_14

  pin_edge_detect #(
    .WIDTH(irq_ctrl_pkg::EDGE_N)
  ) u_edges (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .pin_in({capture_event_in, ext_irq_in}),
    .sel_in(edge_sel),
    .edge_out(pin_edge)
  );

  always_comb begin
    event_set = 9'h000; // RULE_01
    event_set[irq_ctrl_pkg::SRC_EXT0] = pin_edge[0];
    event_set[irq_ctrl_pkg::SRC_EXT1] = pin_edge[1];
    event_set[irq_ctrl_pkg::SRC_EXT2] = pin_edge[2];
    event_set[irq_ctrl_pkg::SRC_EXT3] = pin_edge[3];
    event_set[irq_ctrl_pkg::SRC_EXT4] = pin_edge[4];
    event_set[irq_ctrl_pkg::SRC_TMA] = timer_a_ovf_in; // RULE_16
    event_set[irq_ctrl_pkg::SRC_TMC] = timer_c_ovf_in;
    event_set[irq_ctrl_pkg::SRC_TMD] = timer_d_ovf_in | (capture_mode_in & pin_edge[5]);
    event_set[irq_ctrl_pkg::SRC_SER] = serial_done_in;
  end

  assign req = cur.flag & ~cur.mask; // RULE_07 RULE_02

  // Paired sources fold into one level each.
  assign lvl_req = {req[irq_ctrl_pkg::SRC_SER], // RULE_03
                    req[irq_ctrl_pkg::SRC_TMD] | req[irq_ctrl_pkg::SRC_EXT4],
                    req[irq_ctrl_pkg::SRC_TMC] | req[irq_ctrl_pkg::SRC_EXT3],
                    req[irq_ctrl_pkg::SRC_EXT2], req[irq_ctrl_pkg::SRC_TMA],
                    req[irq_ctrl_pkg::SRC_EXT1], req[irq_ctrl_pkg::SRC_EXT0]};

  irq_priority_pick #(
    .LEVELS(irq_ctrl_pkg::N_LVL)
  ) u_pick (
    .req_in(lvl_req),
    .any_out(any_req),
    .vector_out(pick_vector)
  );

  always_comb begin
    logic [23:0] old_img;
    logic [23:0] img;
    logic [2:0] slot;
    logic [8:0] wflag;
    logic [8:0] wmask;
    logic wie;
    old_img = pack_image(cur.ie, cur.flag, cur.mask);
    img = old_img;
    slot = ctl_slot(bus.addr);
    wflag = 9'h000;
    wmask = 9'h000;
    wie = 1'b0;
    next_cur = cur;
    if (bus.wr && slot != 3'h7) begin // RULE_04
      img[slot*4 +: 4] = bus.wdata;
    end
    wie = img[irq_ctrl_pkg::IE_POS];
    for (int i = 0; i < irq_ctrl_pkg::N_SRC; i++) begin
      wflag[i] = img[irq_ctrl_pkg::F_POS[i]];
      wmask[i] = img[irq_ctrl_pkg::F_POS[i] + 1];
    end
    // A write of one leaves a flag alone; a same-cycle event beats the clear.
    next_cur.flag = (cur.flag & wflag) | event_set; // RULE_05
    next_cur.mask = wmask;
    next_cur.ie = wie;
    if (bus.wr && bus.addr == irq_ctrl_pkg::A_ESEL_A) begin
      next_cur.esel_a = bus.wdata;
    end
    if (bus.wr && bus.addr == irq_ctrl_pkg::A_ESEL_B) begin
      next_cur.esel_b = bus.wdata;
    end
    next_cur.rdata = 4'h0;
    if (bus.rd && slot != 3'h7) begin
      next_cur.rdata = old_img[slot*4 +: 4];
    end
    if (irq_return_in) begin
      next_cur.ie = 1'b1; // RULE_13
      next_cur.sp_low = cur.sp_low + irq_ctrl_pkg::SP_STEP; // RULE_15
    end
    next_cur.push = 1'b0;
    next_cur.jump = 1'b0;
    unique case (cur.fsm)
      irq_ctrl_pkg::ST_IDLE: begin
        if (instr_boundary_in && cur.ie && any_req) begin // RULE_18
          next_cur.fsm = irq_ctrl_pkg::ST_ACK1;
          next_cur.vector = pick_vector; // RULE_08 RULE_17 RULE_11
        end
      end
      irq_ctrl_pkg::ST_ACK1: begin
        next_cur.fsm = irq_ctrl_pkg::ST_ACK2; // RULE_09
        next_cur.push = 1'b1; // RULE_10
      end
      irq_ctrl_pkg::ST_ACK2: begin
        next_cur.fsm = irq_ctrl_pkg::ST_ACK3;
        next_cur.push = 1'b1; // RULE_10
        next_cur.jump = 1'b1; // RULE_09
        // A return in the same cycle still counts, so the two steps cancel.
        next_cur.sp_low = next_cur.sp_low - irq_ctrl_pkg::SP_STEP; // RULE_15
      end
      irq_ctrl_pkg::ST_ACK3: begin
        next_cur.fsm = irq_ctrl_pkg::ST_IDLE;
      end
    endcase
    if (cur.fsm == irq_ctrl_pkg::ST_ACK1) begin
      next_cur.ie = 1'b0; // RULE_09 RULE_13
    end
    next_cur.pending = cur.ie & any_req;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cur.fsm <= irq_ctrl_pkg::ST_IDLE;
      cur.ie <= irq_ctrl_pkg::RST_IE; // RULE_06
      cur.flag <= irq_ctrl_pkg::RST_FLAG;
      cur.mask <= irq_ctrl_pkg::RST_MASK;
      cur.esel_a <= irq_ctrl_pkg::RST_ESEL;
      cur.esel_b <= irq_ctrl_pkg::RST_ESEL;
      cur.rdata <= 4'h0;
      cur.vector <= irq_ctrl_pkg::VEC_RESET;
      cur.sp_low <= irq_ctrl_pkg::RST_SP_LOW;
      cur.push <= 1'b0;
      cur.jump <= 1'b0;
      cur.pending <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata_out = cur.rdata;
  assign ack_phase_out = cur.fsm;
  assign push_out = cur.push;
  assign jump_out = cur.jump;
  assign vector_out = cur.vector;
  assign stack_ptr_out = {irq_ctrl_pkg::SP_TOP, cur.sp_low};
  assign global_irq_enable_out = cur.ie;
  assign irq_pending_out = cur.pending;

  ack_sequence_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_09
    cur.fsm == irq_ctrl_pkg::ST_ACK1 |=> cur.fsm == irq_ctrl_pkg::ST_ACK2 ##1
    cur.fsm == irq_ctrl_pkg::ST_ACK3 ##1 cur.fsm == irq_ctrl_pkg::ST_IDLE)
    else $error("Acknowledge sequence out of order.");

  enable_clear_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_13
    cur.fsm == irq_ctrl_pkg::ST_ACK1 && !irq_return_in |=> !cur.ie)
    else $error("Enable not cleared in acknowledge cycle two.");

  push_window_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_10
    push_out == (cur.fsm == irq_ctrl_pkg::ST_ACK2 || cur.fsm == irq_ctrl_pkg::ST_ACK3))
    else $error("Push strobe outside cycles two and three.");

  jump_vector_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_08
    jump_out |-> vector_out == $past(vector_out, 2) && vector_out != irq_ctrl_pkg::VEC_RESET)
    else $error("Jump without a held vector.");

  gated_start_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_07
    cur.fsm == irq_ctrl_pkg::ST_IDLE && !(instr_boundary_in && cur.ie && any_req)
    |=> cur.fsm == irq_ctrl_pkg::ST_IDLE)
    else $error("Acknowledge started without a serviceable request.");

  no_sw_set_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_05
    ((cur.flag & ~$past(cur.flag)) & ~$past(event_set)) == 9'h000)
    else $error("Request flag set without its event.");

  stack_step_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_15
    cur.fsm == irq_ctrl_pkg::ST_ACK2 && !irq_return_in
    |=> stack_ptr_out == $past(stack_ptr_out) - 10'h004)
    else $error("Stack pointer did not drop by four.");

  top_prio_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_17
    cur.fsm == irq_ctrl_pkg::ST_IDLE && instr_boundary_in && cur.ie && lvl_req[0]
    |=> vector_out == 16'h0002)
    else $error("Highest priority source not chosen.");

  reset_state_a: assert property (@(posedge ref_clk_in) // RULE_06
    srst_in |=> !cur.ie && cur.flag == 9'h000 && cur.mask == 9'h1FF)
    else $error("Reset values wrong.");

  return_set_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_13
    irq_return_in && cur.fsm != irq_ctrl_pkg::ST_ACK1 |=> cur.ie)
    else $error("Return did not set the enable.");

  flag_event_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_16
    event_set != 9'h000 |=> (cur.flag & $past(event_set)) == $past(event_set))
    else $error("Request event did not set its flag.");

  mask_gate_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_07
    cur.fsm == irq_ctrl_pkg::ST_IDLE && req == 9'h000
    |=> cur.fsm == irq_ctrl_pkg::ST_IDLE)
    else $error("Acknowledge started with every request masked.");

  vector_range_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_11
    cur.fsm == irq_ctrl_pkg::ST_ACK1 |-> vector_out[0] == 1'b0 && vector_out >= 16'h0002
    && vector_out <= 16'h000E)
    else $error("Vector outside the interrupt table.");

  boundary_only_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_18
    cur.fsm == irq_ctrl_pkg::ST_IDLE && !instr_boundary_in
    |=> cur.fsm == irq_ctrl_pkg::ST_IDLE)
    else $error("Acknowledge started inside an instruction.");

  stack_return_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_15
    irq_return_in && cur.fsm != irq_ctrl_pkg::ST_ACK2
    |=> stack_ptr_out[5:0] == $past(stack_ptr_out[5:0]) + 6'h04)
    else $error("Stack pointer did not rise by four.");

  pending_flag_a: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RULE_07
    cur.ie && any_req |=> irq_pending_out)
    else $error("Pending output missed a serviceable request.");
endmodule
`default_nettype wire

// ==== logic/irq_ctrl_pkg.sv ====
`default_nettype none
package irq_ctrl_pkg;
  localparam int N_SRC = 9;
  localparam int N_LVL = 7;
  localparam int ADDR_W = 6;
  localparam int EDGE_N = 6;

  // Source indices, in order of priority.
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 1;
  localparam int SRC_TMA = 2;
  localparam int SRC_EXT2 = 3;
  localparam int SRC_TMC = 4;
  localparam int SRC_EXT3 = 5;
  localparam int SRC_TMD = 6;
  localparam int SRC_EXT4 = 7;
  localparam int SRC_SER = 8;

  // Nibble addresses of the control bits.
  localparam logic [5:0] A_CTL0 = 6'h00;
  localparam logic [5:0] A_CTL1 = 6'h01;
  localparam logic [5:0] A_CTL2 = 6'h02;
  localparam logic [5:0] A_CTL3 = 6'h03;
  localparam logic [5:0] A_CTL22 = 6'h22;
  localparam logic [5:0] A_CTL23 = 6'h23;
  localparam logic [5:0] A_ESEL_A = 6'h26;
  localparam logic [5:0] A_ESEL_B = 6'h27;

  // Bit positions in the 24-bit image {ctl23,ctl22,ctl3,ctl2,ctl1,ctl0}.
  // Each source mask sits one bit above its flag.
  localparam int IE_POS = 0;
  localparam int F_POS [N_SRC] = '{2, 4, 6, 16, 10, 20, 12, 22, 14};

  // Edge select codes.
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Reset values, stack pointer top and step sizes.
  localparam logic RST_IE = 1'h0;
  localparam logic [8:0] RST_FLAG = 9'h000;
  localparam logic [8:0] RST_MASK = 9'h1FF;
  localparam logic [3:0] RST_ESEL = 4'h0;
  localparam logic [5:0] RST_SP_LOW = 6'h3F;
  localparam logic [3:0] SP_TOP = 4'hF;
  localparam logic [5:0] SP_STEP = 6'h04;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_STEP = 16'h0002;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ACK1 = 2'h1,
    ST_ACK2 = 2'h3,
    ST_ACK3 = 2'h2
  } ack_state_t;

  typedef struct packed {
    ack_state_t fsm;
    logic ie;
    logic [8:0] flag;
    logic [8:0] mask;
    logic [3:0] esel_a;
    logic [3:0] esel_b;
    logic [3:0] rdata;
    logic [15:0] vector;
    logic [5:0] sp_low;
    logic push;
    logic jump;
    logic pending;
  } ctl_state_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [3:0] wdata;
    logic wr;
    logic rd;
  } nib_bus_t;
endpackage
`default_nettype wire

// ==== logic/pin_edge_detect.sv ====
`timescale 1ns/10ps
`default_nettype none
module pin_edge_detect #(
  parameter int WIDTH = 6
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [2*WIDTH-1:0] sel_in,
  output logic [WIDTH-1:0] edge_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } sync_state_t;

  sync_state_t cur;
  sync_state_t next_cur;

  always_comb begin
    next_cur.meta = pin_in;
    next_cur.sync = cur.meta;
    next_cur.prev = cur.sync;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cur <= '1;
    end else begin
      cur <= next_cur;
    end
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic fall;
    logic rise;
    assign fall = cur.prev[i] & ~cur.sync[i];
    assign rise = ~cur.prev[i] & cur.sync[i];
    always_comb begin
      unique case (sel_in[2*i +: 2])
        irq_ctrl_pkg::EDGE_NONE: edge_out[i] = 1'b0;
        irq_ctrl_pkg::EDGE_FALL: edge_out[i] = fall;
        irq_ctrl_pkg::EDGE_RISE: edge_out[i] = rise;
        irq_ctrl_pkg::EDGE_BOTH: edge_out[i] = fall | rise;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== logic/irq_priority_pick.sv ====
`timescale 1ns/10ps
`default_nettype none
module irq_priority_pick #(
  parameter int LEVELS = 7
) (
  input wire logic [LEVELS-1:0] req_in,
  output logic any_out,
  output logic [15:0] vector_out
);
  // The lowest level number wins, so the loop runs from the top down.
  always_comb begin
    any_out = |req_in;
    vector_out = irq_ctrl_pkg::VEC_RESET;
    for (int i = LEVELS - 1; i >= 0; i--) begin
      if (req_in[i]) begin
        vector_out = 16'((i + 1) * irq_ctrl_pkg::VEC_STEP);
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic jump_in,
  output logic boundary_out,
  output logic return_out
);
  logic [1:0] div;
  logic [3:0] hold;
  // An instruction ends every fourth cycle; a handler returns sixteen cycles after its jump.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      div <= 2'h0;
      hold <= 4'h0;
      boundary_out <= 1'b0;
      return_out <= 1'b0;
    end else begin
      div <= div + 2'h1;
      boundary_out <= (div == 2'h3);
      return_out <= (hold == 4'h1);
      if (jump_in) begin
        hold <= 4'hF;
      end else if (hold != 4'h0) begin
        hold <= hold - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/mcu_interrupt_controller_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module mcu_interrupt_controller_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] ext = 5'h17;
  logic tma = 1'b0;
  logic tmc = 1'b0;
  logic tmd = 1'b0;
  logic ser = 1'b0;
  logic cap = 1'b0;
  logic cap_mode = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [3:0] wdata = 4'h0;
  logic bnd, ret, push, jump, ie, pend;
  logic [3:0] rdata;
  logic [1:0] phase;
  logic [15:0] vec;
  logic [9:0] sp, sp_old;
  int mismatches = 0;
  int cmp_count = 0;
  logic [5:0] rst_a [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h22, 6'h23};
  logic [3:0] rst_d [6] = '{4'h8, 4'hA, 4'h8, 4'hA, 4'h2, 4'hA};
  logic [5:0] clr_a [9] = '{6'h00, 6'h01, 6'h01, 6'h22, 6'h02, 6'h23, 6'h03, 6'h23, 6'h03};
  logic [3:0] clr_d [9] = '{4'h0, 4'h4, 4'h1, 4'h0, 4'h0, 4'h4, 4'h4, 4'h1, 4'h1};
  logic [15:0] vec_e [9] = '{16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000A,
                             16'h000A, 16'h000C, 16'h000C, 16'h000E};

  initial begin
    forever #10 clk = ~clk;
  end

  core_model u_core (.ref_clk_in(clk), .srst_in(srst), .jump_in(jump),
                     .boundary_out(bnd), .return_out(ret));

  irq_controller dut (.ref_clk_in(clk), .srst_in(srst), .ext_irq_in(ext),
    .capture_event_in(cap), .capture_mode_in(cap_mode), .timer_a_ovf_in(tma),
    .timer_c_ovf_in(tmc), .timer_d_ovf_in(tmd), .serial_done_in(ser),
    .instr_boundary_in(bnd), .irq_return_in(ret), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ack_phase_out(phase), .push_out(push),
    .jump_out(jump), .vector_out(vec), .stack_ptr_out(sp), .global_irq_enable_out(ie),
    .irq_pending_out(pend));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic wr_nib(input logic [5:0] a, input logic [3:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [3:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({12'h000, rdata}, {12'h000, e});
  endtask

  // Waits for the acknowledge, walks its three cycles, clears the flag and awaits the return.
  task automatic service(input int i);
    int n;
    n = 0;
    while (phase !== 2'h1 && n < 60) begin
      step();
      n++;
    end
    if (n >= 60) begin
      mismatches++;
      wrap_up();
    end else begin
      chk(vec, vec_e[i]);
      chk({15'h0000, pend}, 16'h0001);
      sp_old = sp;
      step();
      chk({14'h0000, phase}, 16'h0003);
      chk({15'h0000, push}, 16'h0001);
      chk({15'h0000, ie}, 16'h0000);
      step();
      chk({14'h0000, phase}, 16'h0002);
      chk({14'h0000, push, jump}, 16'h0003);
      chk({15'h0000, pend}, 16'h0000);
      step();
      chk({14'h0000, phase}, 16'h0000);
      chk({6'h00, sp}, {6'h00, sp_old - 10'h004});
      wr_nib(clr_a[i], clr_d[i]);
      n = 0;
      while (ie !== 1'b1 && n < 60) begin
        step();
        n++;
      end
      if (n >= 60) begin
        mismatches++;
        wrap_up();
      end
      chk({6'h00, sp}, {6'h00, sp_old});
    end
  endtask

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    step();
    chk(vec, 16'h0000);
    chk({6'h00, sp}, 16'h03FF);
    chk({13'h0000, ie, phase}, 16'h0000);
    for (int i = 0; i < 6; i++) rd_chk(rst_a[i], rst_d[i]);
    rd_chk(6'h10, 4'h0);
    rd_chk(irq_ctrl_pkg::A_ESEL_A, 4'h0);
    $display("test reset done");
    wr_nib(irq_ctrl_pkg::A_CTL1, 4'h5);
    rd_chk(irq_ctrl_pkg::A_CTL1, 4'h0);
    for (int i = 0; i < 6; i++) wr_nib(rst_a[i], 4'h0);
    wr_nib(irq_ctrl_pkg::A_ESEL_A, 4'h9);
    wr_nib(irq_ctrl_pkg::A_ESEL_B, 4'h3);
    @(posedge clk);
    ext <= 5'h08;
    {tma, tmc, tmd, ser} <= 4'hF;
    @(posedge clk);
    {tma, tmc, tmd, ser} <= 4'h0;
    repeat (6) step();
    chk({14'h0000, pend, phase[0]}, 16'h0000);
    rd_chk(irq_ctrl_pkg::A_CTL23, 4'h5);
    rd_chk(irq_ctrl_pkg::A_CTL1, 4'h5);
    rd_chk(irq_ctrl_pkg::A_CTL3, 4'h5);
    $display("test flags done");
    wr_nib(irq_ctrl_pkg::A_CTL0, 4'h5);
    for (int i = 0; i < 9; i++) service(i);
    rd_chk(irq_ctrl_pkg::A_CTL23, 4'h0);
    $display("test priority done");
    wr_nib(irq_ctrl_pkg::A_CTL1, 4'h8);
    @(posedge clk);
    tma <= 1'b1;
    @(posedge clk);
    tma <= 1'b0;
    repeat (10) step();
    chk({13'h0000, pend, phase}, 16'h0000);
    rd_chk(irq_ctrl_pkg::A_CTL1, 4'hC);
    $display("test mask done");
    wr_nib(irq_ctrl_pkg::A_CTL3, 4'h2);
    wr_nib(irq_ctrl_pkg::A_ESEL_B, 4'hB);
    @(posedge clk);
    cap <= 1'b1;
    repeat (6) step();
    rd_chk(irq_ctrl_pkg::A_CTL3, 4'h2);
    wr_nib(irq_ctrl_pkg::A_ESEL_B, 4'h7);
    @(posedge clk);
    {cap_mode, cap} <= 2'h2;
    repeat (6) step();
    rd_chk(irq_ctrl_pkg::A_CTL3, 4'h3);
    chk({13'h0000, pend, phase}, 16'h0000);
    $display("test capture done");
    wrap_up();
  end
endmodule
`default_nettype wire
